/* File: rtl/rss_consts.svh */
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// register byte addresses on the wishbone bus
`define RSS_ADDR_CAUSE     8'h00
`define RSS_ADDR_OSC       8'h04
`define RSS_ADDR_CFG       8'h08

// cause/control register field positions
`define RSS_BIT_TRAP       15
`define RSS_BIT_ILLEGAL    14
`define RSS_BIT_CFGMIS     9
`define RSS_BIT_VREG       8
`define RSS_BIT_EXT        7
`define RSS_BIT_SWRST      6
`define RSS_BIT_WDT        4
`define RSS_BIT_SLEEP      3
`define RSS_BIT_IDLE       2
`define RSS_BIT_BROWN      1
`define RSS_BIT_POWER      0

// implemented bits; 13..10 and 5 read as zero
`define RSS_CAUSE_MASK     16'hC3DF
`define RSS_CAUSE_POR_VAL  16'h0003

// oscillator control: new selection field
`define RSS_OSC_NEW_LSB    8
`define RSS_OSC_NEW_MSB    10
`define RSS_OSC_DEFAULT    3'h0

// reset stretch count; the stretch lasts one cycle longer than this
`define RSS_STRETCH_CYC    4'h4

`endif

/* File: rtl/rss_pkg.sv */
package rss_pkg;
	typedef enum logic [1:0] {
		RSS_RUN,
		RSS_HOLD
	} rss_state_t;
endpackage

/* File: rtl/rss_sync.sv */
`timescale 1ns/10ps
module rss_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// two-stage synchroniser; the first stage is read by the second only
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // rss_sync

/* File: rtl/rss_reset_source_status.sv */
`timescale 1ns/10ps
`include "rss_consts.svh"
module rss_reset_source_status (
	// clock and power-on reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// reset sources, asynchronous levels
	input  wire logic        brownout_in,
	input  wire logic        external_clear_pin_n,
	input  wire logic        reset_instr_in,
	input  wire logic        watchdog_timeout_in,
	input  wire logic        config_mismatch_in,
	input  wire logic        trap_conflict_in,
	input  wire logic        illegal_opcode_in,
	input  wire logic        illegal_addr_mode_in,
	input  wire logic        uninit_wreg_in,
	input  wire logic        security_in,
	// power state reports, asynchronous levels
	input  wire logic        in_sleep,
	input  wire logic        in_idle,
	// configuration word field
	input  wire logic [2:0]  default_osc_select,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// outputs to the device
	output logic             master_system_reset,
	output logic [2:0]       new_osc_select,
	output logic             regulator_sleep_active,
	output logic             regulator_standby
);
	localparam int NSRC = 12;

	logic [NSRC-1:0] src_raw;
	logic [NSRC-1:0] src_s;
	logic            any_src;
	logic [15:0]     cause_r;
	logic [15:0]     cause_nxt;
	logic [15:0]     hw_set;
	logic [2:0]      osc_new_r;
	logic            clr_en_r;
	logic [3:0]      hold_cnt_r;
	rss_pkg::rss_state_t state_r;
	logic            wb_req;
	logic            wb_hit;
	logic            wr_cause;
	logic            wr_osc;
	logic [15:0]     wr_val;
	logic [15:0]     wr_mask;

	// merge the byte enables over the low half word
	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	assign src_raw = {in_idle, in_sleep, security_in, uninit_wreg_in | illegal_addr_mode_in,
		illegal_opcode_in, trap_conflict_in, config_mismatch_in, watchdog_timeout_in,
		reset_instr_in, ~external_clear_pin_n, brownout_in, 1'b0};

	rss_sync #(
		.W(NSRC)
	) u_sync (
		.clock(clock),
		.nrst (nrst),
		.din  (src_raw),
		.dout (src_s)
	);

	// bits 9:1 are reset sources; idle and sleep in 11:10 are status only
	assign any_src = |src_s[9:1];

	// stretch the system reset a few cycles past the last active source
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r    <= rss_pkg::RSS_HOLD;
			hold_cnt_r <= `RSS_STRETCH_CYC;
		end else begin
			case (state_r)
				rss_pkg::RSS_RUN: begin
					if (any_src) begin
						state_r    <= rss_pkg::RSS_HOLD;
						hold_cnt_r <= `RSS_STRETCH_CYC;
					end
				end
				rss_pkg::RSS_HOLD: begin
					if (any_src)
						hold_cnt_r <= `RSS_STRETCH_CYC;
					else if (hold_cnt_r == 4'h0)
						state_r <= rss_pkg::RSS_RUN;
					else
						hold_cnt_r <= hold_cnt_r - 4'h1;
				end
				default: begin
					state_r <= rss_pkg::RSS_HOLD;
				end
			endcase
		end
	end

	// power-on reset itself also holds the system in reset
	assign master_system_reset = (state_r == rss_pkg::RSS_HOLD) || any_src;

	// hardware flag sets from synchronised sources
	always_comb begin
		hw_set                    = 16'h0000;
		hw_set[`RSS_BIT_BROWN]    = src_s[1];
		hw_set[`RSS_BIT_EXT]      = src_s[2];
		hw_set[`RSS_BIT_SWRST]    = src_s[3];
		hw_set[`RSS_BIT_WDT]      = src_s[4];
		hw_set[`RSS_BIT_CFGMIS]   = src_s[5];
		hw_set[`RSS_BIT_TRAP]     = src_s[6];
		hw_set[`RSS_BIT_ILLEGAL]  = src_s[7] | src_s[8];
		hw_set[`RSS_BIT_SLEEP]    = src_s[10];
		hw_set[`RSS_BIT_IDLE]     = src_s[11];
		// the security source resets the system but has no flag of its own
	end

	// wishbone decode; single cycle answer
	assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wb_hit   = (wb_adr_i == `RSS_ADDR_CAUSE) || (wb_adr_i == `RSS_ADDR_OSC) ||
		(wb_adr_i == `RSS_ADDR_CFG);
	assign wr_cause = wb_req && wb_we_i && (wb_adr_i == `RSS_ADDR_CAUSE);
	assign wr_osc   = wb_req && wb_we_i && (wb_adr_i == `RSS_ADDR_OSC);
	assign wr_val   = wb_dat_i[15:0];
	assign wr_mask  = lane_mask(wb_sel_i);

	always_comb begin
		cause_nxt = cause_r;
		// software write only stores; it never feeds the reset path
		if (wr_cause)
			cause_nxt = (cause_r & ~wr_mask) | (wr_val & wr_mask);
		cause_nxt = (cause_nxt | hw_set) & `RSS_CAUSE_MASK;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			cause_r <= `RSS_CAUSE_POR_VAL;
		else
			cause_r <= cause_nxt;
	end

	// bit 8 is owned by software; no source ever sets it
	assign regulator_sleep_active = cause_r[`RSS_BIT_VREG];
	assign regulator_standby      = ~cause_r[`RSS_BIT_VREG];

	// new oscillator selection reloads from the configuration on every reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			osc_new_r <= `RSS_OSC_DEFAULT;
			clr_en_r  <= 1'b1;
		end else begin
			clr_en_r <= master_system_reset;
			if (master_system_reset || clr_en_r)
				osc_new_r <= default_osc_select;
			else if (wr_osc && wb_sel_i[1])
				osc_new_r <= wb_dat_i[`RSS_OSC_NEW_MSB:`RSS_OSC_NEW_LSB];
		end
	end

	assign new_osc_select = osc_new_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req && wb_hit;
			wb_err_o <= wb_req && !wb_hit;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`RSS_ADDR_CAUSE: wb_dat_o <= {16'h0000, cause_r & `RSS_CAUSE_MASK};
					`RSS_ADDR_OSC: begin
						wb_dat_o <= {21'h00_0000, osc_new_r, 8'h00};
					end
					`RSS_ADDR_CFG: wb_dat_o <= {29'h0000_0000, default_osc_select};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // rss_reset_source_status

/* File: tb/rss_chk.sv */
`timescale 1ns/10ps
module rss_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// watched signals
	input wire logic        brownout_in,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [2:0]  default_osc_select,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        master_system_reset,
	input wire logic [2:0]  new_osc_select,
	input wire logic        regulator_sleep_active,
	input wire logic        regulator_standby
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
	a_src_rst: assert property ($rose(brownout_in) |-> ##[1:3] master_system_reset)
		else $error("source did not raise reset");
	a_src_hold: assert property (brownout_in [*4] |-> master_system_reset)
		else $error("reset dropped while source held");
	a_por_stretch: assert property ($rose(nrst) |-> master_system_reset [*4])
		else $error("reset released too soon");
	a_osc_load: assert property ($fell(master_system_reset) |-> new_osc_select == default_osc_select)
		else $error("oscillator selection not reloaded");
	a_ack_once: assert property (wb_ack_o |-> ack_s)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i)
		else $error("ack without request");
	a_err_zero: assert property (wb_err_o |-> !wb_ack_o && wb_dat_o == '0)
		else $error("error answer carries data");
	a_rsvd_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h00 |-> wb_dat_o[13:10] == 4'h0 && !wb_dat_o[5])
		else $error("unimplemented bits not zero");
	a_reg_inv: assert property (regulator_standby != regulator_sleep_active)
		else $error("regulator outputs disagree");
	a_reg_write: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 8'h00
		&& $past(wb_sel_i[1]) |-> regulator_sleep_active == $past(wb_dat_i[8]))
		else $error("regulator bit not written");
endmodule // rss_chk
bind rss_reset_source_status rss_chk u_chk (.clock(clock), .nrst(nrst), .brownout_in(brownout_in),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.default_osc_select(default_osc_select), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.master_system_reset(master_system_reset), .new_osc_select(new_osc_select),
	.regulator_sleep_active(regulator_sleep_active), .regulator_standby(regulator_standby));

/* File: tb/rss_src_model.sv */
`timescale 1ns/10ps
module rss_src_model #(
	parameter int HOLD = 20
) (
	// clock and request
	input  wire logic        clock,
	input  wire logic        go,
	input  wire logic [3:0]  sel,
	// source levels
	output logic      [11:0] lvl
);
	int         cnt_r = 0;
	logic [3:0] src_r = 4'h0;
	// a level, not a pulse, so it survives the input synchronisers
	assign lvl = (cnt_r > 0) ? (12'h001 << src_r) : 12'h000;
	always_ff @(posedge clock) begin
		if (go) begin
			cnt_r <= HOLD;
			src_r <= sel;
		end else if (cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
		end
	end
endmodule // rss_src_model

/* File: tb/rss_reset_source_status_tb.sv */
`timescale 1ns/10ps
module rss_reset_source_status_tb;
	logic        clock, nrst, go, cyc, stb, we, ack, err, msr, rsa, rsb;
	logic [3:0]  sel, bsel;
	logic [7:0]  adr;
	logic [11:0] lvl;
	logic [2:0]  dosc, nosc;
	logic [31:0] wdat, rdat, rnd;
	logic [32:0] expq [$];
	int          err_count, cmp_count, cyc_n;
	integer      seed;
	// flag left by each source; security has no bit of its own
	logic [15:0] flag_t [12] = '{16'h0002, 16'h0080, 16'h0040, 16'h0010, 16'h0200, 16'h8000,
		16'h4000, 16'h4000, 16'h4000, 16'h0000, 16'h0008, 16'h0004};
	rss_src_model #(.HOLD(20)) u_src (.clock(clock), .go(go), .sel(sel), .lvl(lvl));
	rss_reset_source_status dut (.clock(clock), .nrst(nrst), .brownout_in(lvl[0]),
		.external_clear_pin_n(~lvl[1]), .reset_instr_in(lvl[2]), .watchdog_timeout_in(lvl[3]),
		.config_mismatch_in(lvl[4]), .trap_conflict_in(lvl[5]), .illegal_opcode_in(lvl[6]),
		.illegal_addr_mode_in(lvl[7]), .uninit_wreg_in(lvl[8]), .security_in(lvl[9]),
		.in_sleep(lvl[10]), .in_idle(lvl[11]), .default_osc_select(dosc), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .master_system_reset(msr),
		.new_osc_select(nosc), .regulator_sleep_active(rsa), .regulator_standby(rsb));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic give_verdict();
		$display("errors %0d, checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] g, input logic [32:0] x);
		cmp_count++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		if (!w)
			expq.push_back(x);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do
			@(posedge clock);
		while ((ack | err) !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask
	// read answers are taken at the edge that carries them
	always @(posedge clock) begin
		cyc_n++;
		if ((ack | err) === 1'b1 && we === 1'b0)
			cmp({err, rdat}, expq.pop_front());
		if (cyc_n == 3000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		seed = 32'h30c9;
		{nrst, go, cyc, stb, we, sel, adr, wdat, dosc} = '0;
		bsel = 4'hf;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		while (msr !== 1'b0) @(posedge clock);
		bus(1'b0, 8'h00, '0, 33'h0_0000_0003);
		bus(1'b0, 8'h04, '0, '0);
		bus(1'b0, 8'h0c, '0, 33'h1_0000_0000);
		rnd = $random(seed);
		bus(1'b1, 8'h00, rnd, '0);
		repeat (4) @(posedge clock);
		cmp(33'(msr), '0);
		bus(1'b0, 8'h00, '0, {17'h0, rnd[15:0] & 16'hc3df});
		// upper lane only: the low byte must keep what was written before
		bsel <= 4'h2;
		bus(1'b1, 8'h00, 32'h0000_ffff, '0);
		bsel <= 4'hf;
		bus(1'b0, 8'h00, '0, {17'h0, {8'hff, rnd[7:0]} & 16'hc3df});
		bus(1'b1, 8'h04, 32'h0000_0500, '0);
		bus(1'b0, 8'h04, '0, 33'h0_0000_0500);
		cmp(33'(nosc), 33'h5);
		for (int i = 0; i < 12; i++) begin
			bus(1'b1, 8'h00, '0, '0);
			if (i < 10)
				dosc <= 3'($random(seed));
			sel <= 4'(i);
			go  <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			repeat (6) @(posedge clock);
			cmp(33'(msr), 33'(i < 10));
			if (i > 9)
				bus(1'b1, 8'h00, '0, '0);
			while (msr !== 1'b0 || lvl !== 12'h000) @(posedge clock);
			repeat (3) @(posedge clock);
			bus(1'b0, 8'h00, '0, {17'h0, flag_t[i]});
			bus(1'b0, 8'h04, '0, {22'h0, dosc, 8'h00});
		end
		bus(1'b0, 8'h08, '0, {30'h0, dosc});
		// set every flag, then a power-on reset in mid-run must leave only 1:0
		bus(1'b1, 8'h00, 32'h0000_ffff, '0);
		bus(1'b1, 8'h04, 32'h0000_0700, '0);
		cmp(33'({rsb, rsa}), 33'h1);
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		cmp(33'({msr, nosc}), 33'h8);
		nrst <= 1'b1;
		while (msr !== 1'b0) @(posedge clock);
		cmp(33'(nosc), 33'(dosc));
		cmp(33'({rsb, rsa}), 33'h2);
		bus(1'b0, 8'h00, '0, 33'h0_0000_0003);
		give_verdict();
	end
endmodule // rss_reset_source_status_tb
